// file: core/usart_lin_consts.svh
`ifndef USART_LIN_CONSTS_SVH
`define USART_LIN_CONSTS_SVH
// ==========================================
// Register byte offsets.
`define OFS_CMD    8'h00
`define OFS_MODE   8'h04
`define OFS_IENS   8'h08
`define OFS_IENC   8'h0c
`define OFS_IMASK  8'h10
`define OFS_FLAGS  8'h14
`define OFS_RXH    8'h18
`define OFS_TXH    8'h1c
`define OFS_BAUD   8'h20
`define OFS_RTO    8'h24
`define OFS_GUARD  8'h28
`define OFS_RATIO  8'h40
`define OFS_ERRS   8'h44
`define OFS_IRF    8'h4c
`define OFS_BIPH   8'h50
`define OFS_LINCFG 8'h54
`define OFS_LINID  8'h58
`define OFS_WPCFG  8'he4
`define OFS_WPFLG  8'he8
// ==========================================
// Command bit positions.
`define CMD_RXRST   2
`define CMD_TXRST   3
`define CMD_STACLR  8
`define CMD_ARMCHR  11
`define CMD_REARM   15
`define CMD_WAKE    21
// ==========================================
// Field positions and codes.
`define MODE_CHM_LO 14
`define LIN_MASTER  4'ha
`define LIN_SLAVE   4'hb
`define LIN_WAKESEL 6
`define ACT_SEND    2'h0
`define ACT_RECV    2'h1
`define FLG_RXRDY   0
`define FLG_TXRDY   1
`define FLG_TOUT    8
`define FLG_TRANSFER_COMPLETE_FLAG   15
`define WAKE_V20    8'hf0
`define WAKE_V13    8'h80
`define WP_KEY      24'h5a5a5a
// ==========================================
// Reset values.
`define RST_RATIO   32'h00000174
`define RST_BIPH    32'h30011004
`endif

// file: core/usart_lin_pkg.sv
`default_nettype none
package usart_lin_pkg;
	// Channel routing modes.
	typedef enum logic [1:0] {CH_NORMAL, CH_ECHO, CH_LOCAL, CH_REMOTE} chan_mode_e;
	// Transmit serialiser states.
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
endpackage
`default_nettype wire

// file: core/usart_lin_idle_loopback_protect.sv
// Summary of operation
// - In LIN slave mode, DMA requests carry only response data bytes.
// - LIN 2.0 wake sends 0xF0.
// - LIN 1.3 wake sends 0x80.
// - Wake format select picks the character.
// - Wake command sends; completion sets flag.
// - Idle line raises time-out flag.
// - Zero load disables time-out entirely.
// - 17-bit counter, per bit, reload on char.
// - Arm command stops counter, clears flag.
// - Rearm command restarts counting at once.
// - Normal mode wires pins to transceiver.
// - Echo resends RXD, receiver stays active.
// - Local loopback, TXD held high.
// - Remote loopback, RXD straight to TXD.
// - Mode codes normal 0 to remote 3.
// - Protect enable blocks configuration writes.
// - Blocked write flags and records offset.
// - Only correct key clears violation flag.
// - Identifier writable only as LIN master.
// - Receiver reset command at bit 2.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "usart_lin_consts.svh"
module usart_lin_idle_loopback_protect
	import usart_lin_pkg::*;
#(
	parameter int CNT_W = 17
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rxd,
	output logic             txd,
	output logic             tx_dma_req,
	output logic             rx_dma_req
);
	// ==========================================
	// Elaboration check.
	if (CNT_W != 17)
	begin : g_bad
		$error("Idle counter must be 17 bits wide.");
	end

	// Merges a written word into a register under byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				old[8*i +: 8] = nw[8*i +: 8];
		return old;
	endfunction

	// Tells whether an offset is protected when protection is on.
	function automatic logic is_prot(input logic [7:0] a);
		return a == `OFS_MODE || a == `OFS_BAUD || a == `OFS_RTO || a == `OFS_GUARD ||
			a == `OFS_RATIO || a == `OFS_IRF || a == `OFS_BIPH;
	endfunction

	// ==========================================
	// Register bus write side.
	logic [7:0]  aw_addr;      // Held write address.
	logic        aw_hold;      // Write address taken.
	logic [31:0] w_data;       // Held write data.
	logic [3:0]  w_strb;       // Held byte strobes.
	logic        w_hold;       // Write data taken.
	logic        wr_go;        // One-cycle write execution.
	logic [31:0] cmd;          // Command strobes, valid only with wr_go.

	assign awready = !aw_hold && !bvalid;
	assign wready  = !w_hold && !bvalid;
	assign wr_go   = aw_hold && w_hold && !bvalid;
	assign cmd     = (wr_go && aw_addr == `OFS_CMD) ? w_data : 32'h0;

	// Captures address and data in either order, then answers.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			aw_addr <= 8'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_hold <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_go)
			begin
				// Unmapped or read-only targets answer with a slave error.
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_ok(aw_addr) ? 2'h0 : 2'h2;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// Offsets that accept writes.
	function automatic logic wr_ok(input logic [7:0] a);
		return a == `OFS_CMD || a == `OFS_IENS || a == `OFS_IENC || a == `OFS_TXH ||
			a == `OFS_LINCFG || a == `OFS_LINID || a == `OFS_WPCFG || is_prot(a);
	endfunction

	// ==========================================
	// Configuration registers.
	logic [31:0] mode_cfg;     // Channel mode configuration.
	logic [31:0] baud_div;     // Baud divider, low 16 bits used.
	logic [31:0] rto_cfg;      // Idle count load in low 17 bits.
	logic [31:0] guard, ratio, irf, biph; // Stored, not used here.
	logic [31:0] lin_cfg;      // LIN frame configuration.
	logic [7:0]  lin_ident;    // LIN identifier.
	logic [31:0] imask;        // Interrupt enable state.
	logic        wp_en;        // Protect enable.
	logic        wp_viol;      // Protect violation flag.
	logic [15:0] wp_src;       // Offending offset.
	logic        blocked;      // Current write is refused.
	chan_mode_e  chm;          // Decoded channel mode.
	logic [16:0] idle_load;    // Idle count load.

	assign blocked   = wp_en && is_prot(aw_addr);
	assign chm       = chan_mode_e'(mode_cfg[`MODE_CHM_LO +: 2]);
	assign idle_load = rto_cfg[16:0];

	// Applies writes to the configuration registers.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_cfg <= 32'h0;
			baud_div <= 32'h0;
			rto_cfg  <= 32'h0;
			guard    <= 32'h0;
			ratio    <= `RST_RATIO;
			irf      <= 32'h0;
			biph     <= `RST_BIPH;
			lin_cfg  <= 32'h0;
			lin_ident <= 8'h0;
			imask    <= 32'h0;
			wp_en    <= 1'b0;
			wp_viol  <= 1'b0;
			wp_src   <= 16'h0;
		end
		else if (wr_go)
		begin
			if (blocked)
			begin
				// Refused write only leaves a trace.
				wp_viol <= 1'b1;
				wp_src  <= {8'h0, aw_addr};
			end
			else
				case (aw_addr)
					`OFS_MODE:   mode_cfg <= merge(mode_cfg, w_data, w_strb);
					`OFS_BAUD:   baud_div <= merge(baud_div, w_data, w_strb);
					`OFS_RTO:    rto_cfg  <= merge(rto_cfg, w_data, w_strb);
					`OFS_GUARD:  guard    <= merge(guard, w_data, w_strb);
					`OFS_RATIO:  ratio    <= merge(ratio, w_data, w_strb);
					`OFS_IRF:    irf      <= merge(irf, w_data, w_strb);
					`OFS_BIPH:   biph     <= merge(biph, w_data, w_strb);
					`OFS_LINCFG: lin_cfg  <= merge(lin_cfg, w_data, w_strb);
					`OFS_IENS:   imask    <= imask | w_data;
					`OFS_IENC:   imask    <= imask & ~w_data;
					`OFS_LINID:
					begin
						// Only a LIN master may set the identifier.
						if (mode_cfg[3:0] == `LIN_MASTER && w_strb[0])
							lin_ident <= w_data[7:0];
					end
					`OFS_WPCFG:
					begin
						// A wrong key leaves everything as it was.
						if (w_data[31:8] == `WP_KEY)
						begin
							wp_en   <= w_data[0];
							wp_viol <= 1'b0;
						end
					end
					default:
					begin
					end
				endcase
		end
	end

	// ==========================================
	// Bit period divider.
	logic [15:0] div_cnt;      // Cycles left in the current bit.
	logic        bit_tick;     // One pulse per bit period.

	assign bit_tick = (div_cnt == 16'h0);

	// Runs the divider; a zero divisor is treated as one cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || bit_tick)
			div_cnt <= (baud_div[15:0] > 16'h1) ? baud_div[15:0] - 16'h1 : 16'h0;
		else
			div_cnt <= div_cnt - 16'h1;
	end

	// ==========================================
	// Transmitter.
	tx_state_e   tx_st;        // Serialiser state.
	logic [7:0]  tx_sh;        // Shift register.
	logic [2:0]  tx_bit;       // Data bit index.
	logic        tx_line;      // Transmitter output.
	logic        tx_full;      // Holding byte waiting.
	logic [7:0]  tx_hold;      // Holding byte.
	logic        tx_wake;      // Pending or sending a wake character.
	logic        transfer_complete_flag;        // Transfer complete flag.
	logic        tx_load;      // A byte or wake character arrives this cycle.

	// A new arrival must survive the tick that empties the holding slot.
	assign tx_load = (wr_go && aw_addr == `OFS_TXH) || cmd[`CMD_WAKE];

	// Serialises one 8N1 character per holding byte or wake command.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd[`CMD_TXRST] || chm == CH_REMOTE)
		begin
			tx_st   <= TX_IDLE;
			tx_sh   <= 8'h0;
			tx_bit  <= 3'h0;
			tx_line <= 1'b1;
			tx_full <= 1'b0;
			tx_hold <= 8'h0;
			tx_wake <= 1'b0;
		end
		else
		begin
			if (wr_go && aw_addr == `OFS_TXH)
			begin
				tx_full <= 1'b1;
				tx_hold <= w_data[7:0];
			end
			if (cmd[`CMD_WAKE])
			begin
				// Wake character replaces any waiting byte.
				tx_full <= 1'b1;
				tx_wake <= 1'b1;
				tx_hold <= lin_cfg[`LIN_WAKESEL] ? `WAKE_V13 : `WAKE_V20;
			end
			if (bit_tick)
				case (tx_st)
					TX_IDLE:
					begin
						if (tx_full)
						begin
							tx_st   <= TX_START;
							tx_sh   <= tx_hold;
							tx_full <= tx_load;
							tx_line <= 1'b0;
						end
					end
					TX_START:
					begin
						tx_st   <= TX_DATA;
						tx_line <= tx_sh[0];
						tx_sh   <= tx_sh >> 1;
						tx_bit  <= 3'h0;
					end
					TX_DATA:
					begin
						if (tx_bit == 3'h7)
						begin
							tx_st   <= TX_STOP;
							tx_line <= 1'b1;
						end
						else
						begin
							tx_line <= tx_sh[0];
							tx_sh   <= tx_sh >> 1;
							tx_bit  <= tx_bit + 3'h1;
						end
					end
					TX_STOP:
					begin
						tx_st <= TX_IDLE;
						if (!cmd[`CMD_WAKE])
							tx_wake <= 1'b0;
					end
					default:
						tx_st <= TX_IDLE;
				endcase
		end
	end

	// Sets the complete flag after a wake stop bit; setting beats clearing.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			transfer_complete_flag <= 1'b0;
		else if (bit_tick && tx_st == TX_STOP && tx_wake)
			transfer_complete_flag <= 1'b1;
		else if (cmd[`CMD_STACLR])
			transfer_complete_flag <= 1'b0;
	end

	// ==========================================
	// Line routing by channel mode.
	logic rx_in;               // Receiver input after routing.

	// Receiver sees the pin except in the loopback modes.
	always_comb
	begin
		case (chm)
			CH_LOCAL:  rx_in = tx_line;
			CH_REMOTE: rx_in = 1'b1;
			default:   rx_in = rxd;
		endcase
	end

	// Drives the pin from the selected source.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			txd <= 1'b1;
		else
			case (chm)
				CH_NORMAL: txd <= tx_line;
				CH_LOCAL:  txd <= 1'b1;
				default:   txd <= rxd;
			endcase
	end

	// ==========================================
	// Receiver.
	logic        rx_busy;      // Character in progress.
	logic [15:0] rx_cnt;       // Cycles to next sample.
	logic [3:0]  rx_bit;       // Bits sampled, start included.
	logic [7:0]  rx_sh;        // Incoming data.
	logic [7:0]  rx_hold;      // Last character.
	logic        rx_rdy;       // Character waiting.
	logic        rx_done;      // One-cycle end of character.
	logic [7:0]  rd_addr;      // Address of the read being answered.

	// Samples mid-bit after a falling edge on the routed input.
	always_ff @(posedge aclk)
	begin
		rx_done <= 1'b0;
		if (!aresetn || cmd[`CMD_RXRST] || chm == CH_REMOTE)
		begin
			rx_busy <= 1'b0;
			rx_cnt  <= 16'h0;
			rx_bit  <= 4'h0;
			rx_sh   <= 8'h0;
			rx_hold <= 8'h0;
			rx_rdy  <= 1'b0;
			rx_done <= 1'b0;
		end
		else
		begin
			if (rvalid && rready && rd_addr == `OFS_RXH)
				rx_rdy <= 1'b0;
			if (!rx_busy)
			begin
				if (!rx_in)
				begin
					rx_busy <= 1'b1;
					rx_bit  <= 4'h0;
					rx_cnt  <= {1'b0, baud_div[15:1]};
				end
			end
			else if (rx_cnt != 16'h0)
				rx_cnt <= rx_cnt - 16'h1;
			else
			begin
				rx_cnt <= (baud_div[15:0] > 16'h1) ? baud_div[15:0] - 16'h1 : 16'h0;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rx_in)
					rx_busy <= 1'b0;
				else if (rx_bit == 4'h9)
				begin
					rx_busy <= 1'b0;
					rx_hold <= rx_sh;
					rx_rdy  <= 1'b1;
					rx_done <= 1'b1;
				end
				else if (rx_bit != 4'h0)
					rx_sh <= {rx_in, rx_sh[7:1]};
			end
		end
	end

	// ==========================================
	// Bus idle time-out.
	logic [16:0] to_cnt;       // Down counter.
	logic        to_run;       // Counter clock running.
	logic        to_flag;      // Time-out status.

	// Reloads on each character, counts per bit, stops when armed.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || idle_load == 17'h0)
		begin
			to_cnt <= 17'h0;
			to_run <= 1'b0;
		end
		else if (cmd[`CMD_REARM])
		begin
			to_cnt <= idle_load;
			to_run <= 1'b1;
		end
		else if (cmd[`CMD_ARMCHR])
			to_run <= 1'b0;
		else if (rx_done)
		begin
			to_cnt <= idle_load;
			to_run <= 1'b1;
		end
		else if (to_run && bit_tick)
		begin
			to_cnt <= to_cnt - 17'h1;
			if (to_cnt == 17'h1)
				to_run <= 1'b0;
		end
	end

	// Raises the flag at zero; the raise beats the arm command's clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || idle_load == 17'h0)
			to_flag <= 1'b0;
		else if (to_run && bit_tick && to_cnt == 17'h1 && !cmd[`CMD_REARM])
			to_flag <= 1'b1;
		else if (cmd[`CMD_ARMCHR])
			to_flag <= 1'b0;
	end

	// ==========================================
	// DMA requests follow the response action in slave operation.
	logic lin_slv;             // LIN slave selected.

	assign lin_slv    = mode_cfg[3:0] == `LIN_SLAVE;
	assign tx_dma_req = !tx_full && (!lin_slv || lin_cfg[1:0] == `ACT_SEND);
	assign rx_dma_req = rx_rdy && (!lin_slv || lin_cfg[1:0] == `ACT_RECV);

	// ==========================================
	// Register bus read side.

	assign arready = !rvalid;

	// Returns one word per read; unmapped offsets give a slave error.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= 2'h0;
			rd_addr <= 8'h0;
		end
		else if (arvalid && arready)
		begin
			rvalid  <= 1'b1;
			rd_addr <= araddr;
			rresp   <= 2'h0;
			case (araddr)
				`OFS_MODE:   rdata <= mode_cfg;
				`OFS_IMASK:  rdata <= imask;
				`OFS_FLAGS:  rdata <= ({31'h0, rx_rdy} << `FLG_RXRDY) | ({31'h0, !tx_full} << `FLG_TXRDY) |
					({31'h0, to_flag} << `FLG_TOUT) | ({31'h0, transfer_complete_flag} << `FLG_TRANSFER_COMPLETE_FLAG);
				`OFS_RXH:    rdata <= {24'h0, rx_hold};
				`OFS_BAUD:   rdata <= baud_div;
				`OFS_RTO:    rdata <= rto_cfg;
				`OFS_GUARD:  rdata <= guard;
				`OFS_RATIO:  rdata <= ratio;
				`OFS_IRF:    rdata <= irf;
				`OFS_BIPH:   rdata <= biph;
				`OFS_LINCFG: rdata <= lin_cfg;
				`OFS_LINID:  rdata <= {24'h0, lin_ident};
				`OFS_WPCFG:  rdata <= {31'h0, wp_en};
				`OFS_WPFLG:  rdata <= {8'h0, wp_src, 7'h0, wp_viol};
				`OFS_CMD, `OFS_IENS, `OFS_IENC, `OFS_TXH, `OFS_ERRS: rdata <= 32'h0;
				default:
				begin
					rdata <= 32'h0;
					rresp <= 2'h2;
				end
			endcase
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	// ==========================================
	// Checks.
	chk_to_off: assert property (@(posedge aclk) disable iff (!aresetn)
		idle_load == 17'h0 |=> !to_flag) else $error("Time-out flag set while disabled.");
	chk_to_fire: assert property (@(posedge aclk) disable iff (!aresetn)
		to_run && bit_tick && to_cnt == 17'h1 && !cmd[`CMD_REARM] && idle_load != 17'h0 |=> to_flag)
		else $error("Counter reached zero without flag.");
	chk_arm_halt: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd[`CMD_ARMCHR] && !cmd[`CMD_REARM] |=> !to_run && $stable(to_cnt))
		else $error("Arm command did not halt counter.");
	chk_rearm_load: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd[`CMD_REARM] && idle_load != 17'h0 |=> to_run && to_cnt == $past(idle_load))
		else $error("Rearm did not reload counter.");
	chk_local_high: assert property (@(posedge aclk) disable iff (!aresetn)
		chm == CH_LOCAL |=> txd) else $error("Pin not high in local loopback.");
	chk_remote_path: assert property (@(posedge aclk) disable iff (!aresetn)
		chm == CH_REMOTE |=> txd == $past(rxd)) else $error("Remote loopback path broken.");
	chk_prot_block: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && blocked |=> wp_viol && $stable(mode_cfg) && $stable(rto_cfg))
		else $error("Protected write was not refused.");
	chk_ident_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && aw_addr == `OFS_LINID && mode_cfg[3:0] != `LIN_MASTER |=> $stable(lin_ident))
		else $error("Identifier changed outside master mode.");
	chk_wake_done: assert property (@(posedge aclk) disable iff (!aresetn)
		bit_tick && tx_st == TX_STOP && tx_wake |=> transfer_complete_flag) else $error("Wake completion not flagged.");
endmodule
`default_nettype wire

// file: testbench/lin_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus node on the far side of the serial pins.
module lin_bus_node
#(
	parameter int BIT_CYC = 4
)(
	input  wire logic aclk,
	input  wire logic txd,
	output var logic  rxd
);
	logic [7:0] got;   // Last character taken from txd.
	int         n_got; // Characters taken from txd so far.

	// The bus idles recessive, as the pull-up holds it.
	initial
	begin
		rxd = 1'b1;
		got = 8'h00;
		n_got = 0;
	end

	// Sends one 8N1 character, least significant bit first.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge aclk);
			rxd <= f[i];
			repeat (BIT_CYC - 1) @(posedge aclk);
		end
	endtask

	// Collects characters from txd, sampling each bit at its middle.
	always
	begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge aclk);
			got[i] = txd;
		end
		repeat (BIT_CYC) @(posedge aclk);
		n_got++;
	end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usart_lin_consts.svh"
module testbench
	import usart_lin_pkg::*;
;
	localparam logic [31:0] TOUT  = 32'h1 << `FLG_TOUT;  // Time-out flag.
	localparam logic [31:0] RXRDY = 32'h1 << `FLG_RXRDY; // Byte waiting flag.
	localparam logic [31:0] TRANSFER_COMPLETE_FLAG = 32'h1 << `FLG_TRANSFER_COMPLETE_FLAG; // Transfer complete.
	localparam logic [7:0]  RST_OFS [10] = '{8'h10, 8'h18, 8'h24, 8'h40, 8'h4c, 8'h50, 8'h54, 8'h58, 8'he4, 8'he8};
	localparam logic [31:0] RST_VAL [10] = '{32'h0, 32'h0, 32'h0, `RST_RATIO, 32'h0, `RST_BIPH, 32'h0, 32'h0, 32'h0, 32'h0};
	logic        aclk    = 1'b0;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        awvalid;
	logic        wvalid;
	logic        bready;
	logic        arvalid;
	logic        rready;
	logic        awready, wready, bvalid, arready, rvalid, txd, rxd, tx_dma_req, rx_dma_req;
	logic [1:0]  bresp, rresp, brsp, rrsp;
	logic [31:0] rdata, rdat;
	int          err_count = 0;
	int          n_tests   = 0;
	int          k;

	// 125 MHz system clock.
	initial
	begin
		forever #4 aclk = ~aclk;
	end

	usart_lin_idle_loopback_protect #(.CNT_W(17)) i_usart_lin_idle_loopback_protect (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd(rxd), .txd(txd),
		.tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

	lin_bus_node #(.BIT_CYC(4)) i_lin_bus_node (.aclk(aclk), .txd(txd), .rxd(rxd));

	// ==========================================
	// Checking and closing.
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A wait that ran out of cycles counts as a mismatch and ends the run.
	task automatic stall;
		chk(32'h0, 32'h1);
		test_done();
	endtask

	// ==========================================
	// Register bus master: handshakes are judged just before each rising edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int n = 0; n < 200; n++)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			brsp = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb)
			begin
				bready <= 1'b0;
				return;
			end
		end
		stall();
	endtask

	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int n = 0; n < 200; n++)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			rdat = rdata;
			rrsp = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			if (tr)
			begin
				rready <= 1'b0;
				return;
			end
		end
		stall();
	endtask

	// Reads a register and compares the masked bits.
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(rdat & m, e);
	endtask

	// Waits for the node to collect a character from txd.
	task automatic wait_tx(input logic [7:0] e);
		int c;
		c = i_lin_bus_node.n_got;
		for (int n = 0; n < 300; n++)
		begin
			@(posedge aclk);
			if (i_lin_bus_node.n_got != c)
			begin
				chk({24'h0, i_lin_bus_node.got}, {24'h0, e});
				return;
			end
		end
		stall();
	endtask

	// ==========================================
	// Main sequence.
	initial
	begin
		// Idle bus and reset asserted before the first edge.
		aresetn <= 1'b0;
		awaddr  <= 8'h00;
		araddr  <= 8'h00;
		wdata   <= 32'h0;
		wstrb   <= 4'hf;
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		bready  <= 1'b0;
		arvalid <= 1'b0;
		rready  <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 10; i++)
			rchk(RST_OFS[i], '1, RST_VAL[i]);
		rd(8'h2c);
		chk({30'h0, rrsp}, 32'h2);
		wr(`OFS_FLAGS, 32'h0);
		chk({30'h0, brsp}, 32'h2);
		wr(`OFS_BAUD, 32'h4);
		// Identifier writes only count in master configuration.
		wr(`OFS_MODE, {28'h0, `LIN_SLAVE});
		wr(`OFS_LINID, 32'h33);
		rchk(`OFS_LINID, 32'hff, 32'h0);
		wr(`OFS_MODE, {28'h0, `LIN_MASTER});
		wr(`OFS_LINID, 32'h33);
		rchk(`OFS_LINID, 32'hff, 32'h33);
		// Both wake-up formats, each followed by clearing the completion flag.
		for (int w = 0; w < 2; w++)
		begin
			wr(`OFS_LINCFG, 32'(w) << `LIN_WAKESEL);
			wr(`OFS_CMD, 32'h1 << `CMD_WAKE);
			wait_tx(w ? `WAKE_V13 : `WAKE_V20);
			repeat (4) @(posedge aclk);
			rchk(`OFS_FLAGS, TRANSFER_COMPLETE_FLAG, TRANSFER_COMPLETE_FLAG);
			wr(`OFS_CMD, 32'h1 << `CMD_STACLR);
			rchk(`OFS_FLAGS, TRANSFER_COMPLETE_FLAG, 32'h0);
		end
		// Slave transfer requests follow the response action.
		wr(`OFS_MODE, {28'h0, `LIN_SLAVE});
		wr(`OFS_LINCFG, {30'h0, `ACT_SEND});
		chk({30'h0, tx_dma_req, rx_dma_req}, 32'h2);
		wr(`OFS_LINCFG, {30'h0, `ACT_RECV});
		chk({31'h0, tx_dma_req}, 32'h0);
		// Idle time-out: disabled, rearmed, then armed on a character.
		wr(`OFS_RTO, 32'h0);
		wr(`OFS_CMD, 32'h1 << `CMD_REARM);
		repeat (100) @(posedge aclk);
		rchk(`OFS_FLAGS, TOUT, 32'h0);
		wr(`OFS_RTO, 32'ha);
		wr(`OFS_CMD, 32'h1 << `CMD_REARM);
		repeat (20) @(posedge aclk);
		rchk(`OFS_FLAGS, TOUT, 32'h0);
		repeat (40) @(posedge aclk);
		rchk(`OFS_FLAGS, TOUT, TOUT);
		wr(`OFS_CMD, 32'h1 << `CMD_ARMCHR);
		rchk(`OFS_FLAGS, TOUT, 32'h0);
		repeat (100) @(posedge aclk);
		rchk(`OFS_FLAGS, TOUT, 32'h0);
		i_lin_bus_node.send_byte(8'h55);
		repeat (20) @(posedge aclk);
		chk({31'h0, rx_dma_req}, 32'h1);
		rchk(`OFS_FLAGS, TOUT, 32'h0);
		repeat (40) @(posedge aclk);
		rchk(`OFS_FLAGS, TOUT, TOUT);
		wr(`OFS_LINCFG, {30'h0, `ACT_SEND});
		chk({31'h0, rx_dma_req}, 32'h0);
		rchk(`OFS_RXH, 32'hff, 32'h55);
		// Normal routing in both directions.
		wr(`OFS_MODE, 32'(CH_NORMAL) << `MODE_CHM_LO);
		wr(`OFS_TXH, 32'ha5);
		wait_tx(8'ha5);
		i_lin_bus_node.send_byte(8'h3c);
		repeat (4) @(posedge aclk);
		rchk(`OFS_RXH, 32'hff, 32'h3c);
		// Echo: the transmitter is cut off, received bits come back.
		wr(`OFS_MODE, 32'(CH_ECHO) << `MODE_CHM_LO);
		k = i_lin_bus_node.n_got;
		wr(`OFS_TXH, 32'h00);
		repeat (60) @(posedge aclk);
		chk(i_lin_bus_node.n_got, k);
		fork
			i_lin_bus_node.send_byte(8'h96);
			wait_tx(8'h96);
		join
		repeat (4) @(posedge aclk);
		rchk(`OFS_RXH, 32'hff, 32'h96);
		// Local loopback: txd stays high, the character loops inside.
		wr(`OFS_MODE, 32'(CH_LOCAL) << `MODE_CHM_LO);
		k = i_lin_bus_node.n_got;
		wr(`OFS_TXH, 32'h69);
		repeat (60) @(posedge aclk);
		chk(i_lin_bus_node.n_got, k);
		chk({31'h0, txd}, 32'h1);
		rchk(`OFS_RXH, 32'hff, 32'h69);
		wr(`OFS_CMD, 32'h1 << `CMD_ARMCHR);
		wr(`OFS_TXH, 32'h6a);
		repeat (120) @(posedge aclk);
		rchk(`OFS_FLAGS, RXRDY | TOUT, RXRDY | TOUT);
		wr(`OFS_CMD, (32'h1 << `CMD_RXRST) | (32'h1 << `CMD_ARMCHR));
		rchk(`OFS_FLAGS, RXRDY | TOUT, 32'h0);
		// Remote loopback: rxd goes straight back, receiver idle.
		wr(`OFS_MODE, 32'(CH_REMOTE) << `MODE_CHM_LO);
		fork
			i_lin_bus_node.send_byte(8'h17);
			wait_tx(8'h17);
		join
		repeat (4) @(posedge aclk);
		rchk(`OFS_FLAGS, RXRDY, 32'h0);
		// Write protection on two configuration registers.
		wr(`OFS_WPCFG, {`WP_KEY, 8'h01});
		wr(`OFS_BAUD, 32'h7);
		rchk(`OFS_BAUD, '1, 32'h4);
		rchk(`OFS_WPFLG, '1, {16'h0, `OFS_BAUD, 8'h01});
		wr(`OFS_RTO, 32'h7);
		rchk(`OFS_RTO, '1, 32'ha);
		rchk(`OFS_WPFLG, '1, {16'h0, `OFS_RTO, 8'h01});
		wr(`OFS_WPCFG, 32'h12345600);
		rchk(`OFS_WPFLG, 32'h1, 32'h1);
		wr(`OFS_WPCFG, {`WP_KEY, 8'h00});
		rchk(`OFS_WPFLG, 32'h1, 32'h0);
		wr(`OFS_BAUD, 32'h5);
		rchk(`OFS_BAUD, '1, 32'h5);
		wr(`OFS_GUARD, 32'haabbccdd, 4'h5);
		rchk(`OFS_GUARD, '1, 32'h00bb00dd);
		test_done();
	end
endmodule
`default_nettype wire
